// ### vfif_filter.sv
// Purpose : Eight-tap vertical FIR filter with line buffers and load port
// Assumes : All inputs synchronous to clk; rst_n clears control, pipeline and output registers
// Notes   : Memory contents are not cleared by reset
// Behaviour
// - Pixels and coefficients are 12-bit two's complement
// - Eight taps over vertical lines, buffers on chip
// - Line length programmable from 4 to 3076
// - Seven 12-bit line buffers, delay or recirculate
// - Row address selects one of 256 coefficient sets
// - Row address latched when latch enable low
// - Primary pixel input registered on edges with shift enable low
// - Field input registered, used only for field filtering
// - Result leaves on 16-bit registered output
// - Window code n selects bits n+15 to n, codes above 16 acting as 16
// - Optional rounding to the 16-bit word
// - Cascade output feeds next device pixel input
// - Load word writes coefficients and configuration
// - Load word captured only while strobe low
// - Pause freezes the load sequence
// - Interleaved streams up to 3076 values per line
// - All registers update on rising clk only
// - Profile code selects one of sixteen profiles
// - Shift enable low moves data, high holds
`timescale 1ns/10ps
module vfif_filter (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [11:0] pixel_in,
   input  wire logic [11:0] field_pixel_in,
   input  wire logic [11:0] load_word,
   input  wire logic        load_strobe_n,
   input  wire logic        pause,
   input  wire logic [7:0]  coef_row_addr,
   input  wire logic        coef_row_latch_n,
   input  wire logic        shift_hold_n,
   input  wire logic [3:0]  output_profile_sel,
   output logic      [15:0] filtered_out,
   output logic      [11:0] chain_out
);
   localparam int PW = vfif_pkg::PIX_W;
   localparam int CW = vfif_pkg::COEF_W;
   localparam int LB_AW_C = vfif_pkg::LB_AW;

   // Configuration
   logic [11:0]              lineLen;
   logic [3:0]               lbMode;
   logic                     limitEn;
   logic                     cascadeEn;
   logic [vfif_pkg::PROF_W-1:0] profile [vfif_pkg::PROFILES];

   // Load port
   vfif_pkg::vfif_load_t     loadState;
   logic                     strobeWasHigh;
   logic [11:0]              loadAddr;
   logic [2:0]               tapIdx;
   logic [CW-1:0]            rowShadow [vfif_pkg::TAPS-1];
   logic                     take;
   logic                     coefWe;
   logic [CW*vfif_pkg::TAPS-1:0] coefWdata;

   // Datapath
   logic [7:0]               rowAddr;
   logic [CW*vfif_pkg::TAPS-1:0] coefRow;
   logic [PW-1:0]            pixReg;
   logic [PW-1:0]            fieldReg;
   logic [LB_AW_C-1:0]       wrPtr;
   logic [PW-1:0]            lbIn  [vfif_pkg::LBUFS];
   logic [PW-1:0]            lbOut [vfif_pkg::LBUFS];
   logic [11:0]              lbLen [vfif_pkg::LBUFS];
   logic signed [PW-1:0]     tap [vfif_pkg::TAPS];
   logic signed [23:0]       prod [vfif_pkg::TAPS];
   logic signed [vfif_pkg::ACC_W-1:0] next_acc;
   logic signed [vfif_pkg::ACC_W-1:0] acc;
   logic [3:0]               profSel;
   logic [4:0]               winSel;
   logic                     roundEn;
   logic signed [32:0]       rounded;
   logic signed [32:0]       shifted;
   logic [15:0]              next_out;
   logic                     shiftEn;

   assign shiftEn = !shift_hold_n;
   assign take    = !load_strobe_n && !pause;

   // Load port sequencer: only a falling strobe opens a session
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         strobeWasHigh <= 1'b0;
      end else if (load_strobe_n || !pause) begin
         // A pause over the falling strobe keeps the opening edge pending
         strobeWasHigh <= load_strobe_n;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         loadState <= vfif_pkg::LOAD_IDLE;
      end else begin
         unique case (loadState)
            vfif_pkg::LOAD_IDLE: begin
               if (!load_strobe_n && strobeWasHigh && !pause) begin
                  loadState <= vfif_pkg::LOAD_DATA;
               end
            end
            vfif_pkg::LOAD_DATA: begin
               if (load_strobe_n) begin
                  loadState <= vfif_pkg::LOAD_IDLE;
               end
            end
         endcase
      end
   end

   // First word of a session is the start address; words after it are data
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         loadAddr <= 12'h000;
         tapIdx   <= 3'h0;
      end else if (loadState == vfif_pkg::LOAD_IDLE) begin
         if (take && strobeWasHigh) begin
            loadAddr <= load_word;
            tapIdx   <= 3'h0;
         end
      end else if (take) begin
         if (loadAddr[11:8] == vfif_pkg::ADDR_COEF_PAGE) begin
            tapIdx <= tapIdx + 3'h1;
            if (tapIdx == vfif_pkg::LAST_TAP) begin
               loadAddr <= loadAddr + 12'h001;
            end
         end else begin
            loadAddr <= loadAddr + 12'h001;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (loadState == vfif_pkg::LOAD_DATA && take && tapIdx != vfif_pkg::LAST_TAP) begin
         rowShadow[tapIdx] <= load_word;
      end
   end

   assign coefWe = loadState == vfif_pkg::LOAD_DATA && take
                   && loadAddr[11:8] == vfif_pkg::ADDR_COEF_PAGE
                   && tapIdx == vfif_pkg::LAST_TAP;

   always_comb begin
      coefWdata = '0;
      for (int i = 0; i < vfif_pkg::TAPS - 1; i++) begin
         coefWdata[CW*i +: CW] = rowShadow[i];
      end
      coefWdata[CW*(vfif_pkg::TAPS-1) +: CW] = load_word;
   end

   // Configuration and profile writes
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lineLen   <= vfif_pkg::LEN_RESET;
         lbMode    <= vfif_pkg::MODE_RESET;
         limitEn   <= 1'b0;
         cascadeEn <= 1'b0;
      end else if (loadState == vfif_pkg::LOAD_DATA && take
                   && loadAddr[11:8] == vfif_pkg::ADDR_CFG_PAGE) begin
         unique case (loadAddr[1:0])
            vfif_pkg::CFG_LEN:     lineLen   <= load_word;
            vfif_pkg::CFG_MODE:    lbMode    <= load_word[3:0];
            vfif_pkg::CFG_LIMIT:   limitEn   <= load_word[0];
            vfif_pkg::CFG_CASCADE: cascadeEn <= load_word[0];
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         for (int i = 0; i < vfif_pkg::PROFILES; i++) begin
            profile[i] <= '0;
         end
      end else if (loadState == vfif_pkg::LOAD_DATA && take
                   && loadAddr[11:8] == vfif_pkg::ADDR_PROF_PAGE) begin
         profile[loadAddr[3:0]] <= load_word[vfif_pkg::PROF_W-1:0];
      end
   end

   // Coefficient row address
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rowAddr <= 8'h00;
      end else if (!coef_row_latch_n) begin
         rowAddr <= coef_row_addr;
      end
   end

   // Bank of 256 rows, each eight coefficients wide
   vfif_ram #(
      .W  (CW * vfif_pkg::TAPS),
      .D  (vfif_pkg::ROWS),
      .AW (vfif_pkg::ROW_AW)
   ) u_coef (
      .clk   (clk),
      .we    (coefWe),
      .waddr (loadAddr[7:0]),
      .wdata (coefWdata),
      .re    (1'b1),
      .raddr (rowAddr),
      .rdata (coefRow)
   );

   // Input registers move only with shift enable
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pixReg   <= 12'h000;
         fieldReg <= 12'h000;
      end else if (shiftEn) begin
         pixReg   <= pixel_in;
         fieldReg <= field_pixel_in;
      end
   end

   // Shared circular pointer; each buffer reads its own distance behind it
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wrPtr <= '0;
      end else if (shiftEn) begin
         wrPtr <= wrPtr + LB_AW_C'(1);
      end
   end

   // Length is config plus four; first buffer trimmed by two when cascaded
   always_comb begin
      for (int i = 0; i < vfif_pkg::LBUFS; i++) begin
         lbLen[i] = lineLen + vfif_pkg::LEN_OFFSET;
      end
      if (cascadeEn) begin
         lbLen[0] = lineLen + vfif_pkg::LEN_OFFSET - vfif_pkg::CASCADE_TRIM;
      end
   end

   // Buffer input selection: chain, parallel preload or recirculation
   always_comb begin
      for (int i = 0; i < vfif_pkg::LBUFS; i++) begin
         if (lbMode[vfif_pkg::MODE_RECIRC]) begin
            lbIn[i] = lbOut[i];
         end else if (lbMode[vfif_pkg::MODE_PARALLEL] || i == 0) begin
            lbIn[i] = pixReg;
         end else begin
            lbIn[i] = lbOut[i-1];
         end
      end
      if (!lbMode[vfif_pkg::MODE_RECIRC] && lbMode[vfif_pkg::MODE_FIELD_EN]
          && lbMode[vfif_pkg::MODE_FIELD_LB]) begin
         lbIn[vfif_pkg::LBUFS-1] = fieldReg;
      end
   end

   // The read register is the last delay stage, hence length minus one
   for (genvar g = 0; g < vfif_pkg::LBUFS; g++) begin : gLb
      vfif_ram #(
         .W  (PW),
         .D  (vfif_pkg::LB_DEPTH),
         .AW (vfif_pkg::LB_AW)
      ) u_lb (
         .clk   (clk),
         .we    (shiftEn),
         .waddr (wrPtr),
         .wdata (lbIn[g]),
         .re    (shiftEn),
         .raddr (wrPtr - lbLen[g] + 12'h001),
         .rdata (lbOut[g])
      );
   end

   // Taps: current line plus seven delayed lines; field path may replace last
   always_comb begin
      tap[0] = signed'(pixReg);
      for (int i = 1; i < vfif_pkg::TAPS; i++) begin
         tap[i] = signed'(lbOut[i-1]);
      end
      if (lbMode[vfif_pkg::MODE_FIELD_EN] && !lbMode[vfif_pkg::MODE_FIELD_LB]) begin
         tap[vfif_pkg::TAPS-1] = signed'(fieldReg);
      end
   end

   // Products scale pixels by fractional coefficients; sum kept wide
   always_comb begin
      next_acc = '0;
      for (int i = 0; i < vfif_pkg::TAPS; i++) begin
         prod[i]  = tap[i] * signed'(coefRow[CW*i +: CW]);
         next_acc = next_acc + {{8{prod[i][23]}}, prod[i]};
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         acc <= '0;
      end else begin
         acc <= next_acc;
      end
   end

   // Profile code is registered before it steers the output stage
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         profSel <= 4'h0;
      end else begin
         profSel <= output_profile_sel;
      end
   end

   // Codes above sixteen are clamped so the window never leaves the sum
   always_comb begin
      winSel  = profile[profSel][vfif_pkg::PROF_WIN_LSB +: 5];
      roundEn = profile[profSel][vfif_pkg::PROF_ROUND];
      if (winSel > vfif_pkg::WIN_MAX) begin
         winSel = vfif_pkg::WIN_MAX;
      end
   end

   always_comb begin
      rounded = {acc[vfif_pkg::ACC_W-1], acc};
      if (roundEn && winSel != 5'h00) begin
         rounded = rounded + (33'sd1 <<< (winSel - 5'h01));
      end
      shifted = rounded >>> winSel;
      next_out = shifted[15:0];
      if (limitEn && shifted[32:15] != {18{shifted[32]}}) begin
         next_out = shifted[32] ? 16'h8000 : 16'h7FFF;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         filtered_out <= 16'h0000;
      end else begin
         filtered_out <= next_out;
      end
   end

   // Cascade taps the oldest delayed line, registered for the next device
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         chain_out <= 12'h000;
      end else if (shiftEn) begin
         chain_out <= lbOut[vfif_pkg::LBUFS-1];
      end
   end
endmodule

// ### vfif_pkg.sv
// Purpose : Shared constants of the vertical FIR image filter
// Assumes : Load-port addresses of the profile bank are local choices
// Notes   : All widths fixed; nothing here is a parameter
package vfif_pkg;
   localparam int TAPS       = 8;
   localparam int LBUFS      = 7;
   localparam int PIX_W      = 12;
   localparam int COEF_W     = 12;
   localparam int ACC_W      = 32;
   localparam int OUT_W      = 16;
   localparam int ROWS       = 256;
   localparam int ROW_AW     = 8;
   localparam int LB_DEPTH   = 4096;
   localparam int LB_AW      = 12;
   localparam int PROFILES   = 16;
   localparam int PROF_W     = 6;

   // Load-port address map, one 12-bit word per address, eight per coefficient row address
   localparam logic [3:0]  ADDR_COEF_PAGE = 4'h0;
   localparam logic [3:0]  ADDR_PROF_PAGE = 4'h1;
   localparam logic [3:0]  ADDR_CFG_PAGE  = 4'h2;
   localparam logic [1:0]  CFG_LEN        = 2'h0;
   localparam logic [1:0]  CFG_MODE       = 2'h1;
   localparam logic [1:0]  CFG_LIMIT      = 2'h2;
   localparam logic [1:0]  CFG_CASCADE    = 2'h3;

   // Config 1 bit positions
   localparam int MODE_RECIRC   = 0;
   localparam int MODE_PARALLEL = 1;
   localparam int MODE_FIELD_EN = 2;
   localparam int MODE_FIELD_LB = 3;
   // Profile word: window select and round enable
   localparam int PROF_WIN_LSB  = 0;
   localparam int PROF_ROUND    = 5;

   localparam logic [11:0] LEN_RESET     = 12'h0000;
   localparam logic [3:0]  MODE_RESET    = 4'h0;
   localparam logic [11:0] LEN_OFFSET    = 12'h0004;
   localparam logic [11:0] CASCADE_TRIM  = 12'h0002;
   localparam logic [4:0]  WIN_MAX       = 5'h10;
   localparam logic [2:0]  LAST_TAP      = 3'h7;

   typedef enum logic [0:0] {
      LOAD_IDLE = 1'b0,
      LOAD_DATA = 1'b1
   } vfif_load_t;
endpackage

// ### vfif_ram.sv
// Purpose : Simple dual-port memory with registered read data
// Assumes : Read and write to one address in a cycle return old data
// Notes   : Used for the line buffers and the coefficient bank
`timescale 1ns/10ps
module vfif_ram #(
   parameter int W  = 12,
   parameter int D  = 4096,
   parameter int AW = 12
) (
   input  wire logic          clk,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [W-1:0]  wdata,
   input  wire logic          re,
   input  wire logic [AW-1:0] raddr,
   output logic      [W-1:0]  rdata
);
   logic [W-1:0] mem [D];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (re) begin
         rdata <= mem[raddr];
      end
   end
endmodule

// ### vfif_filter_assertions.sv
// Purpose: Port-level checks of the vertical FIR filter
// Assumes: One clk domain, rst_n synchronous and active low
// Notes: Calm counters saturate; six calm edges flush row, tap and output stages
`timescale 1ns/10ps
module vfif_filter_assertions (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic [11:0] pixel_in,
   input wire logic [11:0] field_pixel_in,
   input wire logic [11:0] load_word,
   input wire logic        load_strobe_n,
   input wire logic        pause,
   input wire logic [7:0]  coef_row_addr,
   input wire logic        coef_row_latch_n,
   input wire logic        shift_hold_n,
   input wire logic [3:0]  output_profile_sel,
   input wire logic [15:0] filtered_out,
   input wire logic [11:0] chain_out
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic [2:0] qHold;
   logic [2:0] qLatch;
   logic [2:0] qPause;
   function automatic logic [2:0] sat(input logic [2:0] q);
      return q + {2'h0, q != 3'h7};
   endfunction
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         qHold  <= 3'h0;
         qLatch <= 3'h0;
         qPause <= 3'h0;
      end else begin
         qHold  <= (shift_hold_n && coef_row_latch_n && load_strobe_n
                    && $stable(output_profile_sel)) ? sat(qHold) : 3'h0;
         qLatch <= (shift_hold_n && !coef_row_latch_n && $stable(coef_row_addr)
                    && load_strobe_n && $stable(output_profile_sel)) ? sat(qLatch) : 3'h0;
         qPause <= (shift_hold_n && coef_row_latch_n && pause
                    && $stable(output_profile_sel)) ? sat(qPause) : 3'h0;
      end
   end
   property p_out_hold;
      qHold >= 3'h6 |-> $stable(filtered_out);
   endproperty
   a_out_hold: assert property (p_out_hold) else $error("output moved while held");
   property p_latch_same;
      qLatch >= 3'h6 |-> $stable(filtered_out);
   endproperty
   a_latch_same: assert property (p_latch_same) else $error("same row moved output");
   property p_pause_hold;
      qPause >= 3'h6 |-> $stable(filtered_out);
   endproperty
   a_pause_hold: assert property (p_pause_hold) else $error("paused load moved output");
   property p_chain_hold;
      shift_hold_n |=> $stable(chain_out);
   endproperty
   a_chain_hold: assert property (p_chain_hold) else $error("chain moved while held");
   property p_reset_out;
      disable iff (1'b0) !rst_n |=> filtered_out == 16'h0000;
   endproperty
   a_reset_out: assert property (p_reset_out) else $error("output not cleared");
   property p_reset_chain;
      disable iff (1'b0) !rst_n |=> chain_out == 12'h000;
   endproperty
   a_reset_chain: assert property (p_reset_chain) else $error("chain not cleared");
   property p_release_zero;
      $rose(rst_n) |-> filtered_out == 16'h0000;
   endproperty
   a_release_zero: assert property (p_release_zero) else $error("output not zero");
   property p_chain_release;
      $rose(rst_n) && shift_hold_n |-> chain_out == 12'h000 ##1 chain_out == 12'h000;
   endproperty
   a_chain_release: assert property (p_chain_release) else $error("chain left zero");
endmodule
bind vfif_filter vfif_filter_assertions CHK (.clk, .rst_n, .pixel_in, .field_pixel_in,
   .load_word, .load_strobe_n, .pause, .coef_row_addr, .coef_row_latch_n, .shift_hold_n,
   .output_profile_sel, .filtered_out, .chain_out);

// ### vfif_host.sv
// Purpose: Host load controller model driving the filter's load port
// Assumes: Sessions are called one after another, never overlapped
// Notes: Released word lines show the inverse of the last word
`timescale 1ns/10ps
module vfif_host (
   input  wire logic        clk,
   output logic      [11:0] loadWord,
   output logic             loadStrobeN,
   output logic             pause
);
   initial begin
      loadWord    = 12'h000;
      loadStrobeN = 1'b1;
      pause       = 1'b0;
   end
   // A junk word stands under pause, so a capture while paused would show
   task automatic session(input logic [11:0] addr, input logic [11:0] w[$], input int stallAt);
      @(posedge clk);
      loadStrobeN <= 1'b0;
      loadWord    <= addr;
      foreach (w[i]) begin
         @(posedge clk);
         if (i == stallAt) begin
            pause    <= 1'b1;
            loadWord <= ~w[i];
            repeat (8) @(posedge clk);
            pause <= 1'b0;
         end
         loadWord <= w[i];
      end
      @(posedge clk);
      loadStrobeN <= 1'b1;
      loadWord    <= ~loadWord;
   endtask
endmodule

// ### vfif_filter_bench.sv
// Purpose: Self-checking bench for the vertical FIR image filter
// Assumes: A constant pixel run settles every tap to that pixel outside field and recirculate modes
// Notes: Sums are checked in steady state; tap spacing shows on the cascade word
`timescale 1ns/10ps
module vfif_filter_bench;
   typedef struct packed {
      logic [7:0]  row;
      logic [11:0] pix;
      logic [3:0]  prof;
      logic [15:0] exp;
   } vfif_case_t;
   logic        clk;
   logic        rstN;
   logic [11:0] pix;
   logic [11:0] fieldPix;
   logic [7:0]  rowAddr;
   logic        rowLatchN;
   logic        shiftHoldN;
   logic [3:0]  profSel;
   logic [11:0] loadWord;
   logic        loadStrobeN;
   logic        pause;
   logic [15:0] filtOut;
   logic [11:0] chainOut;
   logic [11:0] coefs[$];
   logic [11:0] lenVal;
   int          dly;
   int          n_errors;
   int          n_tests;
   vfif_case_t  cases [9] = '{
      '{8'h00, 12'h003, 4'h0, 16'h1800}, '{8'h01, 12'h005, 4'h0, 16'hC000},
      '{8'h02, 12'h007, 4'h1, 16'h0004}, '{8'h02, 12'h007, 4'h2, 16'h0003},
      '{8'h01, 12'h7FF, 4'h3, 16'hFE00}, '{8'h01, 12'h7FF, 4'h4, 16'hFE00},
      '{8'h00, 12'h800, 4'h3, 16'hFFC0}, '{8'h03, 12'h009, 4'h0, 16'h0009},
      '{8'hFF, 12'hFFD, 4'h0, 16'hFF58}};
   vfif_filter DUT (.clk(clk), .rst_n(rstN), .pixel_in(pix), .field_pixel_in(fieldPix),
      .load_word(loadWord), .load_strobe_n(loadStrobeN), .pause(pause),
      .coef_row_addr(rowAddr), .coef_row_latch_n(rowLatchN), .shift_hold_n(shiftHoldN),
      .output_profile_sel(profSel), .filtered_out(filtOut), .chain_out(chainOut));
   vfif_host HOST (.clk(clk), .loadWord(loadWord), .loadStrobeN(loadStrobeN), .pause(pause));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   function automatic logic [11:0] coefOf(input int r, input int t);
      case (r)
         0: return 12'h100;
         1: return 12'h800;
         2: return 12'h001;
         3: return (t == 7) ? 12'h001 : 12'h000;
         default: return 12'h007;
      endcase
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic apply(input vfif_case_t c);
      @(posedge clk);
      rowAddr   <= c.row;
      rowLatchN <= 1'b0;
      pix       <= c.pix;
      profSel   <= c.prof;
      tick(60);
      chk("filtered_out", c.exp, filtOut);
   endtask
   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      #400000;
      n_errors++;
      wrap_up();
   end
   initial begin
      n_errors = 0;
      n_tests = 0;
      rstN = 1'b0;
      pix = 12'h000;
      fieldPix = 12'h064;
      rowAddr = 8'h00;
      rowLatchN = 1'b1;
      shiftHoldN = 1'b1;
      profSel = 4'h0;
      repeat (4) @(posedge clk);
      rstN <= 1'b1;
      tick(0);
      chk("filtered_out", 16'h0000, filtOut);
      chk("chain_out", 16'h0000, {4'h0, chainOut});
      @(posedge clk);
      shiftHoldN <= 1'b0;
      for (int r = 0; r < 5; r++) for (int t = 0; t < 8; t++) coefs.push_back(coefOf(r, t));
      HOST.session(12'h000, coefs[0:31], -1);
      HOST.session(12'h0FF, coefs[32:39], -1);
      HOST.session(12'h100, '{12'h000, 12'h024, 12'h004, 12'h030, 12'h01F}, -1);
      foreach (cases[i]) apply(cases[i]);
      @(posedge clk);
      shiftHoldN <= 1'b1;
      rowLatchN  <= 1'b1;
      rowAddr    <= 8'h01;
      pix        <= 12'h005;
      tick(10);
      chk("filtered_out", 16'hFF58, filtOut);
      chk("chain_out", 16'h0FFD, {4'h0, chainOut});
      @(posedge clk);
      rowLatchN <= 1'b0;
      rowAddr   <= 8'hFF;
      tick(10);
      chk("filtered_out", 16'hFF58, filtOut);
      @(posedge clk);
      rowLatchN <= 1'b1;
      HOST.session(12'h105, '{12'h025}, 0);
      @(posedge clk);
      shiftHoldN <= 1'b0;
      apply('{8'h02, 12'h007, 4'h5, 16'h0002});
      HOST.session(12'h201, '{12'h004, 12'h001}, -1);
      apply('{8'h03, 12'h009, 4'h0, 16'h0064});
      apply('{8'h01, 12'h005, 4'h0, 16'h8000});
      for (int k = 0; k < 3; k++) begin
         lenVal = (k == 0) ? 12'hC00 : 12'h000;
         dly    = 7 * (lenVal + 4) + ((k == 2) ? 0 : 2);
         HOST.session(12'h200, '{lenVal, 12'h004, 12'h001, {11'h000, k == 2}}, -1);
         @(posedge clk);
         pix <= 12'h111;
         tick(dly + 20);
         @(posedge clk);
         pix <= 12'h222;
         tick(dly - 1);
         chk("chain_out", 16'h0111, {4'h0, chainOut});
         tick(1);
         chk("chain_out", 16'h0222, {4'h0, chainOut});
      end
      // Mid-run reset clears outputs and configuration, not the memories
      @(posedge clk);
      rstN       <= 1'b0;
      shiftHoldN <= 1'b1;
      tick(2);
      chk("filtered_out", 16'h0000, filtOut);
      chk("chain_out", 16'h0000, {4'h0, chainOut});
      @(posedge clk);
      rstN <= 1'b1;
      tick(2);
      chk("chain_out", 16'h0000, {4'h0, chainOut});
      @(posedge clk);
      shiftHoldN <= 1'b0;
      apply('{8'h01, 12'h005, 4'h0, 16'hC000});
      HOST.session(12'h201, '{12'h001}, -1);
      apply('{8'h03, 12'h009, 4'h0, 16'h0005});
      HOST.session(12'h201, '{12'h002}, -1);
      @(posedge clk);
      pix <= 12'h333;
      tick(6);
      chk("chain_out", 16'h0333, {4'h0, chainOut});
      HOST.session(12'h201, '{12'h00C}, -1);
      tick(12);
      chk("chain_out", 16'h0064, {4'h0, chainOut});
      wrap_up();
   end
endmodule
